// ### acr_pkg.sv
/*
 Constants shared by the converter configuration bank and its host controller.
 Assumes both ends run on one clock, aclk, at 10 MHz.
*/
// Notes on behaviour
// - Hold bit freezes estimate, last value applied.
// - Hold bit clear keeps estimate updating.
// - Bits five to two set loop time constant.
// - Global gate hands low-speed to channel bits.
// - Swing enable 00 off, 11 on; 01/10 forbidden.
// - Channel A low-speed bit needs gate first.
// - Channel B low-speed bit needs gate first.
// - Host sets six fast-rate bits above threshold.
// - Host writes zero to every reserved bit.
// - All ten registers reset to zero.
// - Correction enable bit switches loop on.
// - Digital enable gates all digital functions; the code gates only the offset correction loop and hold with it.
package acr_pkg;
	// ----------------------------------------
	// Device register map
	// ----------------------------------------
	localparam int NREG = 10;
	localparam logic [NREG-1:0][7:0] REG_OFS = {8'hf2, 8'hf1, 8'hef, 8'hdb, 8'hd7,
		8'hd5, 8'hcf, 8'h42, 8'h3d, 8'h02};
	localparam logic [NREG-1:0][7:0] REG_MASK = {8'h08, 8'h03, 8'h10, 8'h21, 8'h0c,
		8'h18, 8'hbc, 8'h08, 8'h20, 8'h40};
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [3:0] IX_PERF_A = 4'h0;
	localparam logic [3:0] IX_DC_EN = 4'h1;
	localparam logic [3:0] IX_DIGITAL = 4'h2;
	localparam logic [3:0] IX_HOLD = 4'h3;
	localparam logic [3:0] IX_PERF_B = 4'h4;
	localparam logic [3:0] IX_PERF_C = 4'h5;
	localparam logic [3:0] IX_PERF_D = 4'h6;
	localparam logic [3:0] IX_GATE = 4'h7;
	localparam logic [3:0] IX_SWING = 4'h8;
	localparam logic [3:0] IX_SLOW_A = 4'h9;
	localparam int B_DC_EN = 5;
	localparam int B_DIGITAL = 3;
	localparam int B_HOLD = 7;
	localparam int B_TC_LO = 2;
	localparam int B_GATE = 4;
	localparam int B_SLOW_A = 3;
	localparam int B_SLOW_B = 0;
	localparam logic [1:0] SWING_ON = 2'h3;
	localparam logic [1:0] SWING_OFF = 2'h0;
	// Values written by the fast-rate preset, one per register in order.
	localparam logic [3:0][7:0] PRE_OFS = {8'hdb, 8'hd7, 8'hd5, 8'h02};
	localparam logic [3:0][7:0] PRE_VAL = {8'h20, 8'h0c, 8'h18, 8'h40};
	// ----------------------------------------
	// Correction loop
	// ----------------------------------------
	localparam int SW = 12;
	localparam int FRAC = 8;
	localparam int EW = SW + 1 + FRAC;
	// ----------------------------------------
	// Controller registers on AXI4-Lite
	// ----------------------------------------
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_PRESET = 8'h08;
	localparam int C_WR = 16;
	localparam int C_RD = 17;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	function automatic logic [4:0] reg_find(input logic [7:0] a);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < NREG; i++) begin
			if (REG_OFS[i] == a) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction
endpackage

// ### acr_cfg_if.sv
/*
 Register port joining the configuration bank and its host controller.
 Assumes both ends share aclk; a read strobe is answered on the next edge.
*/
`timescale 1ns/1ps
interface acr_cfg_if (
	input wire logic aclk
);
	logic wr_stb;
	logic rd_stb;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;
	modport dev (
		input wr_stb,
		input rd_stb,
		input addr,
		input wdata,
		output rdata,
		output rvalid
	);
	modport host (
		output wr_stb,
		output rd_stb,
		output addr,
		output wdata,
		input rdata,
		input rvalid
	);
endinterface

// ### acr_dev.sv
/*
 Configuration bank of a dual-channel converter and its offset loop.
 Assumes samples arrive on aclk in offset binary, one per channel per edge.
*/
`timescale 1ns/1ps
module acr_dev (
	input wire logic aclk,
	input wire logic aresetn,
	acr_cfg_if.dev cfg,
	input wire logic [1:0][11:0] samp_in,
	output logic [1:0][11:0] samp_out,
	output logic slow_mode_chan_a,
	output logic slow_mode_chan_b,
	output logic swing_ctrl_en,
	output logic hold_dc_estimate,
	output logic [5:0] fast_rate_tune
);
	typedef struct packed {
		logic [acr_pkg::NREG-1:0][7:0] regs;
		logic [1:0][acr_pkg::EW-1:0] est;
		logic [1:0][11:0] samp;
		logic [7:0] rdata;
		logic rvalid;
	} acr_dev_st_t;

	acr_dev_st_t st_r;
	acr_dev_st_t st_nxt;
	logic [4:0] hit;
	logic dig_en;
	logic dc_en;
	logic [3:0] dc_loop_time_const;
	logic [1:0][acr_pkg::EW-1:0] est_upd;
	logic [1:0][11:0] corrected;

	// ----------------------------------------
	// Decoded controls
	// ----------------------------------------
	assign hit = acr_pkg::reg_find(cfg.addr);
	assign dig_en = st_r.regs[acr_pkg::IX_DIGITAL][acr_pkg::B_DIGITAL];
	// Correction runs only with both enables set.
	assign dc_en = dig_en && st_r.regs[acr_pkg::IX_DC_EN][acr_pkg::B_DC_EN];
	assign hold_dc_estimate = dc_en && st_r.regs[acr_pkg::IX_HOLD][acr_pkg::B_HOLD];
	assign dc_loop_time_const = st_r.regs[acr_pkg::IX_HOLD][acr_pkg::B_TC_LO +: 4];
	// Channel bits count only behind the global gate.
	assign slow_mode_chan_a = st_r.regs[acr_pkg::IX_GATE][acr_pkg::B_GATE]
		&& st_r.regs[acr_pkg::IX_SLOW_A][acr_pkg::B_SLOW_A];
	assign slow_mode_chan_b = st_r.regs[acr_pkg::IX_GATE][acr_pkg::B_GATE]
		&& st_r.regs[acr_pkg::IX_PERF_D][acr_pkg::B_SLOW_B];
	// The forbidden codes fall back to fixed swing rather than half-enable.
	assign swing_ctrl_en = (st_r.regs[acr_pkg::IX_SWING][1:0] == acr_pkg::SWING_ON);
	assign fast_rate_tune = {st_r.regs[acr_pkg::IX_PERF_D][5],
		st_r.regs[acr_pkg::IX_PERF_C][2], st_r.regs[acr_pkg::IX_PERF_C][3],
		st_r.regs[acr_pkg::IX_PERF_B][3], st_r.regs[acr_pkg::IX_PERF_B][4],
		st_r.regs[acr_pkg::IX_PERF_A][6]};
	assign cfg.rdata = st_r.rdata;
	assign cfg.rvalid = st_r.rvalid;
	assign samp_out = st_r.samp;

	// ----------------------------------------
	// Offset loop, one per channel
	// ----------------------------------------
	// A first-order leaky average of the centred sample; the shift sets the
	// time constant, trading settling speed for noise on the estimate.
	for (genvar c = 0; c < 2; c++) begin : g_chan
		logic signed [acr_pkg::EW-1:0] target;
		logic signed [acr_pkg::EW:0] diff;
		logic signed [acr_pkg::EW:0] step;
		assign target = {{2{~samp_in[c][11]}}, samp_in[c][10:0], {acr_pkg::FRAC{1'b0}}};
		assign diff = {target[acr_pkg::EW-1], target}
			- {st_r.est[c][acr_pkg::EW-1], st_r.est[c]};
		assign step = diff >>> dc_loop_time_const;
		assign est_upd[c] = acr_pkg::EW'(st_r.est[c] + step[acr_pkg::EW-1:0]);
		assign corrected[c] = 12'(samp_in[c] - 12'(st_r.est[c][acr_pkg::EW-1:acr_pkg::FRAC]));
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.rvalid = 1'b0;
		if (cfg.wr_stb && hit[4]) begin
			// Reserved positions are not stored, so they always read zero.
			st_nxt.regs[hit[3:0]] = cfg.wdata & acr_pkg::REG_MASK[hit[3:0]];
		end
		if (cfg.rd_stb) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata = hit[4] ? st_r.regs[hit[3:0]] : 8'h00;
		end
		for (int c = 0; c < 2; c++) begin
			if (!dc_en) begin
				st_nxt.est[c] = '0;
				st_nxt.samp[c] = samp_in[c];
			end else begin
				if (!hold_dc_estimate) begin
					st_nxt.est[c] = est_upd[c];
				end
				// While held, the stored estimate still corrects each sample.
				st_nxt.samp[c] = corrected[c];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule // acr_dev

// ### acr_host.sv
/*
 Host controller that programs the configuration bank from AXI4-Lite.
 Assumes one AXI4-Lite master on aclk and the bank on the same clock.
*/
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module acr_host (
	input wire logic aclk,
	input wire logic aresetn,
	acr_cfg_if.host cfg,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_PRE = 2'b10
	} acr_hst_t;

	typedef struct packed {
		acr_hst_t st;
		logic [1:0] step;
		logic aw_f;
		logic w_f;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic wr_stb;
		logic rd_stb;
		logic [7:0] addr;
		logic [7:0] wdata_o;
		logic [7:0] rd_cap;
		logic err;
		logic gate;
		logic chan_b;
	} acr_host_st_t;

	acr_host_st_t s_r;
	acr_host_st_t s_nxt;

	assign s_axi_awready = !s_r.aw_f;
	assign s_axi_wready = !s_r.w_f;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign cfg.wr_stb = s_r.wr_stb;
	assign cfg.rd_stb = s_r.rd_stb;
	assign cfg.addr = s_r.addr;
	assign cfg.wdata = s_r.wdata_o;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic [4:0] f;
		logic [7:0] a;
		logic [7:0] d;
		logic bad;
		s_nxt = s_r;
		f = 5'h00;
		a = 8'h00;
		d = 8'h00;
		bad = 1'b0;
		s_nxt.wr_stb = 1'b0;
		s_nxt.rd_stb = 1'b0;
		if (s_axi_awvalid && !s_r.aw_f) begin
			s_nxt.aw_f = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_r.w_f) begin
			s_nxt.w_f = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = acr_pkg::RESP_OK;
			unique case (s_axi_araddr)
				acr_pkg::A_STATUS: s_nxt.rdata = {16'h0000, s_r.rd_cap, 6'h00, s_r.err,
					s_r.st != ST_IDLE};
				acr_pkg::A_CMD, acr_pkg::A_PRESET: s_nxt.rdata = 32'h00000000;
				default: begin
					s_nxt.rdata = 32'h00000000;
					s_nxt.rresp = acr_pkg::RESP_ERR;
				end
			endcase
		end
		unique case (s_r.st)
			ST_IDLE: ;
			ST_WAIT: if (cfg.rvalid) begin
				s_nxt.rd_cap = cfg.rdata;
				s_nxt.st = ST_IDLE;
			end
			ST_PRE: begin
				// All six fast-rate bits in four writes.
				// The channel B bit is kept only behind the gate, or the preset
				// would set it with the gate clear.
				s_nxt.wr_stb = 1'b1;
				s_nxt.addr = acr_pkg::PRE_OFS[s_r.step];
				s_nxt.wdata_o = acr_pkg::PRE_VAL[s_r.step]
					| {7'h00, s_r.step == 2'h3 && s_r.chan_b && s_r.gate};
				s_nxt.step = 2'(s_r.step + 2'h1);
				if (s_r.step == 2'h3) begin
					s_nxt.st = ST_IDLE;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
		if (s_r.aw_f && s_r.w_f && !s_r.bvalid) begin
			s_nxt.aw_f = 1'b0;
			s_nxt.w_f = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = acr_pkg::RESP_OK;
			a = s_r.wdata[15:8];
			f = acr_pkg::reg_find(a);
			// Reserved positions are forced to zero before they go out.
			d = f[4] ? (s_r.wdata[7:0] & acr_pkg::REG_MASK[f[3:0]]) : s_r.wdata[7:0];
			bad = (a == acr_pkg::REG_OFS[acr_pkg::IX_SWING]) && s_r.wdata[acr_pkg::C_WR]
				&& (d[1:0] != acr_pkg::SWING_ON) && (d[1:0] != acr_pkg::SWING_OFF);
			// A channel low-speed bit is refused until the gate is set.
			if (!s_r.gate && ((a == acr_pkg::REG_OFS[acr_pkg::IX_SLOW_A] && d[acr_pkg::B_SLOW_A])
				|| (a == acr_pkg::REG_OFS[acr_pkg::IX_PERF_D] && d[acr_pkg::B_SLOW_B]))) begin
				bad = s_r.wdata[acr_pkg::C_WR];
			end
			if (!s_r.wstrb[0] || !s_r.wstrb[1] || !s_r.wstrb[2]) begin
				s_nxt.bresp = acr_pkg::RESP_ERR;
			end else if (s_r.awaddr == acr_pkg::A_CMD
				&& (s_r.wdata[acr_pkg::C_WR] || s_r.wdata[acr_pkg::C_RD])) begin
				if (s_r.st != ST_IDLE || bad) begin
					s_nxt.err = 1'b1;
				end else begin
					s_nxt.err = 1'b0;
					s_nxt.addr = a;
					s_nxt.wdata_o = d;
					if (s_r.wdata[acr_pkg::C_WR]) begin
						s_nxt.wr_stb = 1'b1;
						if (a == acr_pkg::REG_OFS[acr_pkg::IX_GATE]) begin
							s_nxt.gate = d[acr_pkg::B_GATE];
						end
						if (a == acr_pkg::REG_OFS[acr_pkg::IX_PERF_D]) begin
							s_nxt.chan_b = d[acr_pkg::B_SLOW_B];
						end
					end else begin
						s_nxt.rd_stb = 1'b1;
						s_nxt.st = ST_WAIT;
					end
				end
			end else if (s_r.awaddr == acr_pkg::A_PRESET && s_r.wdata[0]) begin
				if (s_r.st != ST_IDLE) begin
					s_nxt.err = 1'b1;
				end else begin
					s_nxt.err = 1'b0;
					s_nxt.st = ST_PRE;
					s_nxt.step = 2'h0;
				end
			end else if (s_r.awaddr != acr_pkg::A_CMD && s_r.awaddr != acr_pkg::A_PRESET) begin
				s_nxt.bresp = acr_pkg::RESP_ERR;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule // acr_host

// ### acr_sva.sv
/*
 Checker of the register port between the configuration bank and its host.
 Assumes it sees the port signals of one interface, all on aclk.
*/
`timescale 1ns/1ps
module acr_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wr_stb,
	input wire logic rd_stb,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic gate_r;
	logic hit;
	logic [7:0] msk;
	// Shadow of the gate as last written on the port, as the bank would see it.
	always_ff @(posedge aclk) begin
		if (!aresetn) gate_r <= 1'b0;
		else if (wr_stb && addr == 8'hef) gate_r <= wdata[4];
	end
	always_comb begin
		hit = 1'b0;
		msk = 8'h00;
		for (int i = 0; i < acr_pkg::NREG; i++) begin
			if (acr_pkg::REG_OFS[i] == addr) begin
				hit = 1'b1;
				msk = acr_pkg::REG_MASK[i];
			end
		end
	end
	rd_ans_a: assert property (rd_stb |=> rvalid) else $error("read not answered");
	rv_cause_a: assert property (rvalid |-> $past(rd_stb)) else $error("stray read answer");
	rd_pulse_a: assert property (rd_stb |=> !rd_stb) else $error("read strobe too long");
	swing_code_a: assert property (wr_stb && addr == 8'hf1 |-> wdata[1:0] inside {2'h0, 2'h3})
		else $error("forbidden swing code");
	resv_zero_a: assert property (wr_stb && hit |-> (wdata & ~msk) == 8'h00)
		else $error("reserved bit written");
	gate_chan_a_a: assert property (wr_stb && addr == 8'hf2 && wdata[3] |-> gate_r)
		else $error("chan A slow bit before gate");
	gate_chan_b_a: assert property (wr_stb && addr == 8'hdb && wdata[0] |-> gate_r)
		else $error("chan B slow bit before gate");
	preset_seq_a: assert property (wr_stb && addr == 8'h02 ##1 wr_stb |->
		addr == 8'hd5 && wdata == 8'h18 ##1 wr_stb && addr == 8'hd7 && wdata == 8'h0c
		##1 wr_stb && addr == 8'hdb && wdata[5]) else $error("preset sequence wrong");
	cover property (rvalid);
	cover property (wr_stb && addr == 8'hdb);
	cover property (wr_stb && addr == 8'hf1);
endmodule // acr_sva

// ### adc_offset_lowspeed_perf_config_regs_tb.sv
/*
 Testbench joining bank and host, driving AXI4-Lite and the sample inputs.
 Assumes the command, status and preset registers of the host on AXI4-Lite.
*/
`timescale 1ns/1ps
module adc_offset_lowspeed_perf_config_regs_tb;
	logic aclk, aresetn, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv, sla, slb, swg, hld;
	logic [7:0] awa, ara;
	logic [31:0] wd, rd;
	logic [1:0] br, rr;
	logic [1:0][11:0] sin, sout;
	logic [5:0] frt;
	logic [3:0] ws;
	int num_errors = 0;
	int checks_done = 0;
	int cyc = 0;
	acr_cfg_if acr_cfg_if_i (.aclk(aclk));
	acr_dev acr_dev_i (.aclk(aclk), .aresetn(aresetn), .cfg(acr_cfg_if_i), .samp_in(sin),
		.samp_out(sout), .slow_mode_chan_a(sla), .slow_mode_chan_b(slb), .swing_ctrl_en(swg),
		.hold_dc_estimate(hld), .fast_rate_tune(frt));
	acr_host acr_host_i (.aclk(aclk), .aresetn(aresetn), .cfg(acr_cfg_if_i),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rry));
	acr_sva acr_sva_i (.aclk(aclk), .aresetn(aresetn), .wr_stb(acr_cfg_if_i.wr_stb),
		.rd_stb(acr_cfg_if_i.rd_stb), .addr(acr_cfg_if_i.addr), .wdata(acr_cfg_if_i.wdata),
		.rdata(acr_cfg_if_i.rdata), .rvalid(acr_cfg_if_i.rvalid));
	task end_sim;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (awv && awr) begin
				ta = 1'b1;
				awv <= 1'b0;
			end
			if (wv && wr) begin
				tw = 1'b1;
				wv <= 1'b0;
			end
		end
		do @(posedge aclk); while (bv !== 1'b1);
		r = br;
		// Bready stays high, so no time step both drops and raises it.
	endtask
	task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge aclk); while (arr !== 1'b1);
		arv <= 1'b0;
		do @(posedge aclk); while (rv !== 1'b1);
		d = rd;
		r = rr;
	endtask
	// A command is finished once the status shows the host idle again.
	task cmd(input logic [7:0] o, input logic [7:0] d, input logic rdo, output logic [31:0] st);
		logic [1:0] r;
		axw(acr_pkg::A_CMD, {14'h0000, rdo, !rdo, o, d}, r);
		do axr(acr_pkg::A_STATUS, st, r); while (st[0] !== 1'b0);
	endtask
	task t_reset;
		logic [31:0] st;
		logic [1:0] r;
		for (int i = 0; i < acr_pkg::NREG; i++) begin
			cmd(acr_pkg::REG_OFS[i], 8'h00, 1'b1, st);
			chk("reset value", 32'h0, {24'h0, st[15:8]});
		end
		chk("tune at reset", 32'h0, {26'h0, frt});
		axr(8'h0c, st, r);
		chk("unmapped rresp", {30'h0, acr_pkg::RESP_ERR}, {30'h0, r});
		axw(acr_pkg::A_PRESET, 32'h0, r);
		chk("preset bresp", {30'h0, acr_pkg::RESP_OK}, {30'h0, r});
		axw(8'h0c, 32'h0, r);
		chk("unmapped bresp", {30'h0, acr_pkg::RESP_ERR}, {30'h0, r});
		ws <= 4'h3;
		axw(acr_pkg::A_PRESET, 32'h0, r);
		ws <= 4'hf;
		chk("strobe bresp", {30'h0, acr_pkg::RESP_ERR}, {30'h0, r});
	endtask
	task t_slow;
		logic [31:0] st;
		cmd(8'hf2, 8'h08, 1'b0, st);
		chk("gate missing", 32'h1, {31'h0, st[1]});
		cmd(8'hef, 8'h10, 1'b0, st);
		cmd(8'hf2, 8'h08, 1'b0, st);
		cmd(8'hdb, 8'h01, 1'b0, st);
		chk("slow modes", 32'h3, {30'h0, slb, sla});
		cmd(8'hef, 8'h00, 1'b0, st);
		chk("gate cleared", 32'h0, {30'h0, slb, sla});
	endtask
	task t_swing;
		logic [31:0] st;
		cmd(8'hf1, 8'h01, 1'b0, st);
		chk("swing refused", 32'h2, {30'h0, st[1], swg});
		cmd(8'hf1, 8'h03, 1'b0, st);
		chk("swing on", 32'h1, {31'h0, swg});
		cmd(8'hf1, 8'h00, 1'b0, st);
		chk("swing off", 32'h0, {31'h0, swg});
	endtask
	task t_resv;
		logic [31:0] st;
		logic [1:0] r;
		cmd(8'hcf, 8'hff, 1'b0, st);
		chk("hold inactive", 32'h0, {31'h0, hld});
		cmd(8'hcf, 8'h00, 1'b1, st);
		chk("hold reg", 32'hbc, {24'h0, st[15:8]});
		cmd(8'hcf, 8'h00, 1'b0, st);
		axw(acr_pkg::A_PRESET, 32'h1, r);
		do axr(acr_pkg::A_STATUS, st, r); while (st[0] !== 1'b0);
		chk("fast tune", 32'h3f, {26'h0, frt});
	endtask
	// With a zero time constant the estimate settles in one sample.
	task t_loop;
		logic [31:0] st;
		sin <= {12'h900, 12'h900};
		cmd(8'h3d, 8'h20, 1'b0, st);
		repeat (4) @(posedge aclk);
		chk("digital off", 32'h900900, {8'h0, sout});
		cmd(8'h42, 8'h08, 1'b0, st);
		repeat (4) @(posedge aclk);
		chk("tracking", 32'h800800, {8'h0, sout});
		cmd(8'hcf, 8'h80, 1'b0, st);
		sin <= {12'h950, 12'h950};
		repeat (4) @(posedge aclk);
		chk("frozen", 32'h1850850, {7'h0, hld, sout});
		cmd(8'h3d, 8'h00, 1'b0, st);
		repeat (4) @(posedge aclk);
		chk("loop off", 32'h0950950, {7'h0, hld, sout});
		// With a time constant of one the estimate stops one fraction step short
		// above midcode and lands exactly below it.
		cmd(8'hcf, 8'h04, 1'b0, st);
		sin <= {12'h700, 12'h950};
		cmd(8'h3d, 8'h20, 1'b0, st);
		repeat (40) @(posedge aclk);
		chk("slow loop", 32'h800801, {8'h0, sout});
	endtask
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			num_errors++;
			end_sim;
		end
	end
	initial begin
		{aresetn, awv, wv, bry, arv, rry, awa, ara, wd} = '0;
		sin = '0;
		ws = 4'hf;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_slow;
		t_swing;
		t_resv;
		t_loop;
		end_sim;
	end
endmodule // adc_offset_lowspeed_perf_config_regs_tb
